//--- design/sic_status_lamps.sv
// Status lamp controller: green run lamp and yellow calibration lamp.
// Assumes all status inputs are synchronous levels from the module core logic.
`timescale 1ns/100ps

// Flash phase generator shared by both lamps.
// The next phase is handed out so that a lamp register shows a new phase at the edge that makes it.
module sic_flash_div #(
    parameter int unsigned HALF_PERIOD_CYC = sic_pkg::HALF_PERIOD_CYC,
    parameter int unsigned CNT_W           = sic_pkg::CNT_W
) (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Flash phase
    output logic      phase_nxt_out
);
    logic [CNT_W-1:0] div_cnt_r;
    logic [CNT_W-1:0] div_cnt_nxt;
    logic             phase_r;
    logic             phase_nxt;

    // The counter wraps after HALF_PERIOD_CYC cycles, so the on and off phases are equally long.
    always_comb begin
        div_cnt_nxt = div_cnt_r + 1'h1;
        phase_nxt   = phase_r;
        if (div_cnt_r >= CNT_W'(HALF_PERIOD_CYC - 1)) begin
            div_cnt_nxt = '0;
            phase_nxt   = ~phase_r;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt_r <= '0;
            phase_r   <= 1'h1;
        end else begin
            div_cnt_r <= div_cnt_nxt;
            phase_r   <= phase_nxt;
        end
    end

    assign phase_nxt_out = phase_nxt;
endmodule

// Link state tracker: waiting for initialization, link up, link lost.
// Once the link has been up, a loss never sends it back to waiting for initialization.
module sic_link_fsm (
    // Clock and reset
    input  wire logic           clk_sys_in,
    input  wire logic           rst_n_in,
    // Controller status
    input  wire logic           init_done_in,
    input  wire logic           init_error_in,
    input  wire logic           link_ok_in,
    // Link state
    output sic_pkg::sic_state_t state_out
);
    sic_pkg::sic_state_t state_r;
    sic_pkg::sic_state_t state_nxt;

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            sic_pkg::SIC_WAIT_INIT: begin
                // Faulty initialization data never brings the link up.
                if (init_done_in && !init_error_in && link_ok_in) begin
                    state_nxt = sic_pkg::SIC_LINK_UP;
                end
            end
            sic_pkg::SIC_LINK_UP: begin
                if (!link_ok_in) begin
                    state_nxt = sic_pkg::SIC_LINK_DOWN;
                end
            end
            sic_pkg::SIC_LINK_DOWN: begin
                if (link_ok_in) begin
                    state_nxt = sic_pkg::SIC_LINK_UP;
                end
            end
            default: begin
                state_nxt = sic_pkg::SIC_WAIT_INIT;
            end
        endcase
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_r <= sic_pkg::SIC_WAIT_INIT;
        end else begin
            state_r <= state_nxt;
        end
    end

    assign state_out = state_r;
endmodule

// One lamp driver; both lamps use the same one, fed by the shared flash phase.
module sic_lamp_drv (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Lamp request
    input  wire logic steady_in,
    input  wire logic flash_in,
    input  wire logic phase_nxt_in,
    // Lamp
    output logic      lamp_out
);
    logic lamp_r;
    logic lamp_nxt;

    // Steady wins over flashing; with neither request the lamp stays dark.
    always_comb begin
        if (steady_in) begin
            lamp_nxt = 1'h1;
        end else if (flash_in) begin
            lamp_nxt = phase_nxt_in;
        end else begin
            lamp_nxt = 1'h0;
        end
    end

    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            lamp_r <= 1'h0;
        end else begin
            lamp_r <= lamp_nxt;
        end
    end

    assign lamp_out = lamp_r;
endmodule

module sic_status_lamps #(
    parameter int unsigned HALF_PERIOD_CYC = sic_pkg::HALF_PERIOD_CYC
) (
    // Clock and reset
    input  wire logic clk_sys_in,
    input  wire logic rst_n_in,
    // Module status
    input  wire logic init_done_in,
    input  wire logic init_error_in,
    input  wire logic link_ok_in,
    input  wire logic cal_mode_in,
    input  wire logic cal_running_in,
    // Lamps
    output logic      run_lamp_out,
    output logic      cal_lamp_out
);
    sic_pkg::sic_state_t state_w;
    logic                phase_nxt_w;
    logic                run_steady_w;
    logic                run_flash_w;
    logic                cal_steady_w;
    logic                cal_flash_w;

    // One divider drives both lamps so their flashing stays in phase.
    sic_flash_div #(
        .HALF_PERIOD_CYC (HALF_PERIOD_CYC),
        .CNT_W           (sic_pkg::CNT_W)
    ) sic_flash_div_i (
        .clk_sys_in      (clk_sys_in),
        .rst_n_in        (rst_n_in),
        .phase_nxt_out   (phase_nxt_w)
    );

    sic_link_fsm sic_link_fsm_i (
        .clk_sys_in      (clk_sys_in),
        .rst_n_in        (rst_n_in),
        .init_done_in    (init_done_in),
        .init_error_in   (init_error_in),
        .link_ok_in      (link_ok_in),
        .state_out       (state_w)
    );

    // Lamp requests follow the registered link state, so a lamp lags its state by one edge.
    always_comb begin
        run_steady_w = 1'h0;
        run_flash_w  = 1'h0;
        cal_steady_w = 1'h0;
        cal_flash_w  = 1'h0;
        if (state_w == sic_pkg::SIC_LINK_UP) begin
            run_steady_w = 1'h1;
        end else begin
            run_flash_w  = 1'h1;
        end
        if (!cal_mode_in) begin
            cal_flash_w  = 1'h0;
        end else if (state_w != sic_pkg::SIC_LINK_UP) begin
            cal_flash_w  = 1'h0;
        end else if (cal_running_in) begin
            cal_steady_w = 1'h1;
        end else begin
            // Idle before a run and after one ends look the same.
            cal_flash_w  = 1'h1;
        end
    end

    sic_lamp_drv sic_lamp_drv_run_i (
        .clk_sys_in      (clk_sys_in),
        .rst_n_in        (rst_n_in),
        .steady_in       (run_steady_w),
        .flash_in        (run_flash_w),
        .phase_nxt_in    (phase_nxt_w),
        .lamp_out        (run_lamp_out)
    );

    sic_lamp_drv sic_lamp_drv_cal_i (
        .clk_sys_in      (clk_sys_in),
        .rst_n_in        (rst_n_in),
        .steady_in       (cal_steady_w),
        .flash_in        (cal_flash_w),
        .phase_nxt_in    (phase_nxt_w),
        .lamp_out        (cal_lamp_out)
    );
endmodule

//--- inc/sic_pkg.sv
// Constants for the status lamp controller of a six-channel RTD input module.
// Assumes a single 250 MHz system clock and status levels from the module core.
// Notes on behaviour
// - Green flashes 4 Hz awaiting initialization data
// - Green steady once initialization succeeds
// - Bad init data: no link, green flashes
// - Link lost flashes green, restored goes steady
// - Yellow off in running mode
// - Calibration idle: yellow flashes at 4 Hz
// - Calibration run: yellow steadily lit
// - Run finished: yellow returns to flashing
// - No link in calibration mode: yellow off
package sic_pkg;
    localparam int unsigned CLK_HZ        = 250_000_000;
    localparam int unsigned FLASH_PER_SEC = 4;
    // One full on/off flash period is a quarter second; each phase is half of that.
    localparam int unsigned HALF_PERIOD_CYC = CLK_HZ / (FLASH_PER_SEC * 2);
    localparam int unsigned CNT_W           = 25;

    typedef enum logic [2:0] {
        SIC_WAIT_INIT = 3'h1,
        SIC_LINK_UP   = 3'h2,
        SIC_LINK_DOWN = 3'h4
    } sic_state_t;
endpackage

//--- dv/sic_ctrl_model.sv
// Controller model: hands over init data and holds the link.
// The bench picks a good or a faulty data set.
`timescale 1ns/100ps
module sic_ctrl_model (
    // Good or faulty data set chosen by the bench
    input  wire logic g_in,
    input  wire logic b_in,
    // Controller status seen by the lamp controller
    output logic      d_out,
    output logic      e_out,
    output logic      o_out
);
    // A faulty set still comes over a live link, so the lamp logic must refuse it itself.
    assign {d_out, e_out, o_out} = {g_in | b_in, b_in, g_in | b_in};
endmodule

//--- dv/sic_lamp_monitor.sv
// Port checks for the status lamp controller.
// Bound into every instance; HALF_PERIOD_CYC is handed on.
`timescale 1ns/100ps
module sic_lamp_monitor #(
    parameter int unsigned HALF_PERIOD_CYC = 4
) (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic rst_n_in,
    // Status inputs of the lamp controller
    input wire logic init_done_in,
    input wire logic init_error_in,
    input wire logic link_ok_in,
    input wire logic cal_mode_in,
    input wire logic cal_running_in,
    // Lamps
    input wire logic run_lamp_out,
    input wire logic cal_lamp_out
);
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    wire ok = link_ok_in && init_done_in && !init_error_in, r = run_lamp_out, c = cal_lamp_out;
    property p_a; ok[*2] |=> r; endproperty
    a_a: assert property (p_a) else $error("a");
    property p_b; $rose(link_ok_in) ##0 ok[*2] |=> r; endproperty
    a_b: assert property (p_b) else $error("b");
    property p_c; (!link_ok_in)[*8] |-> r != $past(r, HALF_PERIOD_CYC); endproperty
    a_c: assert property (p_c) else $error("c");
    property p_d; !cal_mode_in |=> !c; endproperty
    a_d: assert property (p_d) else $error("d");
    property p_e; (ok && cal_mode_in && !cal_running_in)[*8] |-> c != $past(c, HALF_PERIOD_CYC); endproperty
    a_e: assert property (p_e) else $error("e");
    property p_f; ok[*2] ##0 (cal_mode_in && cal_running_in) |=> c; endproperty
    a_f: assert property (p_f) else $error("f");
    property p_g; (!link_ok_in)[*2] |=> !c; endproperty
    a_g: assert property (p_g) else $error("g");
    property p_h; c |-> r; endproperty
    a_h: assert property (p_h) else $error("h");
endmodule
bind sic_status_lamps sic_lamp_monitor #(.HALF_PERIOD_CYC(HALF_PERIOD_CYC)) sic_lamp_monitor_i (.*);

//--- dv/sic_status_lamps_tb_top.sv
// Bench for the status lamp controller.
// Half period cut to 4 cycles so a flash takes 8.
`timescale 1ns/100ps
module sic_status_lamps_tb_top;
    logic clk_sys_in = 0, rst_n_in = 0, g = 0, b = 0, cal_mode_in = 1, cal_running_in = 0, x;
    logic init_done_in, init_error_in, link_ok_in, run_lamp_out, cal_lamp_out;
    int fails = 0, tests_run = 0;
    sic_ctrl_model sic_ctrl_model_i (.g_in(g), .b_in(b), .d_out(init_done_in), .e_out(init_error_in), .o_out(link_ok_in));
    sic_status_lamps #(.HALF_PERIOD_CYC(4)) sic_status_lamps_i (.*);
    task w(int n); repeat (n) @(negedge clk_sys_in); endtask
    task chk(logic a, e); tests_run++; if (a !== e) begin fails++; $display("BAD %0t %h %h", $time, a, e); end endtask
    task fr; x = run_lamp_out; w(4); chk(run_lamp_out, ~x); endtask
    task fc; x = cal_lamp_out; w(4); chk(cal_lamp_out, ~x); endtask
    task s1; w(10); fr; chk(cal_lamp_out, 0); endtask
    task s2; b = 1; w(10); fr; endtask
    task s3; b = 0; g = 1; w(5); chk(run_lamp_out, 1); fc; endtask
    task s4; cal_running_in = 1; w(2); chk(cal_lamp_out, 1); cal_running_in = 0; w(2); fc; endtask
    task s5; g = 0; w(3); fr; chk(cal_lamp_out, 0); g = 1; w(3); chk(run_lamp_out, 1); endtask
    task s6; cal_mode_in = 0; repeat (5) begin w(2); chk(cal_lamp_out, 0); end endtask
    task conclude; $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish; endtask
    initial forever #2 clk_sys_in = ~clk_sys_in;
    initial begin
        w(4);
        rst_n_in = 1;
        s1;
        s2;
        s3;
        s4;
        s5;
        s6;
        conclude;
    end
endmodule
